/* File: verilog/acmpc_pkg.sv */
/*
 analog comparator control: register offsets, field positions, reset values,
 power-mode codes and the packed carriers shared by the design files.
 assumes a 32-bit apb with one aligned word per register.
*/
package acmpc_pkg;

    localparam logic [11:0] ACMPC_CSC_OFFSET     = 12'h000;
    localparam logic [11:0] ACMPC_PWR_OFFSET     = 12'h004;

    localparam int ACMPC_ENABLE_BIT  = 7;
    localparam int ACMPC_REFSEL_BIT  = 6;
    localparam int ACMPC_FLAG_BIT    = 5;
    localparam int ACMPC_IRQEN_BIT   = 4;
    localparam int ACMPC_RESULT_BIT  = 3;
    localparam int ACMPC_PINEN_BIT   = 2;
    localparam int ACMPC_EDGE_LSB    = 0;
    localparam int ACMPC_EDGE_W      = 2;

    localparam logic [7:0] ACMPC_CSC_RESET = 8'h00;

    localparam logic [1:0] ACMPC_EDGE_FALL  = 2'h0;
    localparam logic [1:0] ACMPC_EDGE_RISE  = 2'h1;
    localparam logic [1:0] ACMPC_EDGE_FALL2 = 2'h2;
    localparam logic [1:0] ACMPC_EDGE_BOTH  = 2'h3;

    localparam int ACMPC_SYNC_STAGES = 3;

    // power state presented by the system
    typedef enum logic [1:0] {
        ACMPC_PWR_RUN   = 2'h0,
        ACMPC_PWR_WAIT  = 2'h1,
        ACMPC_PWR_LSTOP = 2'h2,
        ACMPC_PWR_DSTOP = 2'h3
    } acmpc_pwr_t;

    typedef struct packed {
        logic       comparator_enable;
        logic       reference_input_select;
        logic       compare_event_flag;
        logic       compare_irq_enable;
        logic       comparator_result_bit;
        logic       result_pin_enable;
        logic [1:0] event_edge_select;
    } acmpc_csc_t;

    typedef struct packed {
        logic       psel;
        logic       penable;
        logic       pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } acmpc_apb_req_t;

endpackage

/* File: verilog/acmpc_sync.sv */
/*
 three-stage synchroniser with agreement filter for an asynchronous level.
 assumes input is free of glitches shorter than a clock period.
*/
`timescale 1ns/100ps
module acmpc_sync (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic async_in,
    output logic      sync_out
);
    logic [2:0] stage;
    logic [2:0] next_stage;
    logic       next_sync_out;

    // stage[0] feeds only stage[1]; compare stage[1] and stage[2]
    always_comb begin
        next_stage    = {stage[1:0], async_in};
        next_sync_out = (stage[1] == stage[2]) ? stage[2] : sync_out;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stage    <= 3'h0;
            sync_out <= 1'b0;
        end else begin
            stage    <= next_stage;
            sync_out <= next_sync_out;
        end
    end
endmodule // acmpc_sync

/* File: verilog/acmpc_top.sv */
/*
 analog comparator control block: apb status/control register, result
 synchronisation, edge event flag, interrupt, output pin, power modes.
 assumes the analog comparator outside drives comparator_raw and takes
 comparator_power_on and reference_input_select; pwr_state from system.
*/
`timescale 1ns/100ps
module acmpc_top
    import acmpc_pkg::*;
(
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [11:0]       paddr,
    input  wire logic [31:0]       pwdata,
    input  wire logic [3:0]        pstrb,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire acmpc_pkg::acmpc_pwr_t pwr_state,
    input  wire logic              debug_halt,
    input  wire logic              comparator_raw,
    output logic                   comparator_power_on,
    output logic                   reference_input_select,
    output logic                   comparator_out_pin,
    output logic                   compare_irq
);
    import acmpc_pkg::*;

    function automatic logic edge_hit(input logic [1:0] mode, input logic prev,
                                      input logic cur);
        logic rise;
        logic fall;
        rise = !prev && cur;
        fall = prev && !cur;
        case (mode)
            ACMPC_EDGE_RISE: edge_hit = rise;
            ACMPC_EDGE_BOTH: edge_hit = rise || fall;
            default:         edge_hit = fall;
        endcase
    endfunction

    acmpc_csc_t csc;
    acmpc_csc_t next_csc;
    logic       result_sync;
    logic       result_prev;
    logic       next_result_prev;
    logic       next_pready;
    logic [31:0] next_prdata;
    logic       next_pslverr;
    logic       next_power_on;
    logic       next_refsel;
    logic       next_pin;
    logic       next_irq;
    logic       in_stop;
    logic       deep_stop;
    logic       active;
    logic       wr_csc;
    logic       setup;
    logic       event_hit;
    logic       addr_ok;

    acmpc_sync u_sync (
        .pclk     (pclk),
        .presetn  (presetn),
        .async_in (comparator_raw),
        .sync_out (result_sync)
    );

    // debug halt needs no term: runs as in run mode
    always_comb begin
        in_stop   = (pwr_state == ACMPC_PWR_LSTOP) || (pwr_state == ACMPC_PWR_DSTOP);
        deep_stop = (pwr_state == ACMPC_PWR_DSTOP);
        // active only when enabled; wait keeps it running
        active    = csc.comparator_enable && !in_stop;
        setup     = psel && !penable;
        addr_ok   = (paddr == ACMPC_CSC_OFFSET);
        wr_csc    = psel && penable && pready && pwrite && addr_ok && pstrb[0];
        // edge select; no events while stopped
        event_hit = active && edge_hit(csc.event_edge_select, result_prev, result_sync);
    end

    always_comb begin
        next_csc         = csc;
        // tracks while idle so enabling never sees a false edge
        next_result_prev = result_sync;
        // edge history frozen with the clocks in light stop
        if (pwr_state == ACMPC_PWR_LSTOP)
            next_result_prev = result_prev;
        else if (deep_stop)
            next_result_prev = 1'b0;
        if (wr_csc) begin
            next_csc.comparator_enable      = pwdata[ACMPC_ENABLE_BIT];
            next_csc.reference_input_select = pwdata[ACMPC_REFSEL_BIT];
            next_csc.compare_irq_enable     = pwdata[ACMPC_IRQEN_BIT];
            next_csc.result_pin_enable      = pwdata[ACMPC_PINEN_BIT];
            next_csc.event_edge_select      =
                pwdata[ACMPC_EDGE_LSB +: ACMPC_EDGE_W];
            if (pwdata[ACMPC_FLAG_BIT])
                next_csc.compare_event_flag = 1'b0;
        end
        if (event_hit)
            next_csc.compare_event_flag = 1'b1;
        // new enable used, so a disabling write shows no stale one
        next_csc.comparator_result_bit =
            (next_csc.comparator_enable && !in_stop) ? result_sync : 1'b0;
        // light stop: clocks halted, every bit held as entered
        if (pwr_state == ACMPC_PWR_LSTOP)
            next_csc = csc;
        // deep stop returns everything to reset values
        if (deep_stop)
            next_csc = ACMPC_CSC_RESET;
    end

    // zero-wait apb slave
    always_comb begin
        next_pready  = setup;
        next_prdata  = 32'h0000_0000;
        next_pslverr = 1'b0;
        if (setup) begin
            if (addr_ok)
                next_prdata = {24'h00_0000, csc};
            else if (paddr == ACMPC_PWR_OFFSET)
                next_prdata = {30'h0000_0000, pwr_state};
            else
                next_pslverr = 1'b1;
            if (pwrite)
                next_prdata = 32'h0000_0000;
            if (pwrite && paddr == ACMPC_PWR_OFFSET)
                next_pslverr = 1'b1;
        end
    end

    always_comb begin
        // stop turns comparator off; otherwise enable rules
        next_power_on = next_csc.comparator_enable && !in_stop;
        next_refsel   = next_csc.reference_input_select;
        // pin carries result only when enabled
        next_pin      = next_csc.result_pin_enable && next_csc.comparator_result_bit;
        // irq from flag; never raised in stop
        next_irq      = next_csc.compare_irq_enable && next_csc.compare_event_flag
                        && !in_stop;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            csc                    <= ACMPC_CSC_RESET;
            result_prev            <= 1'b0;
            pready                 <= 1'b0;
            prdata                 <= 32'h0000_0000;
            pslverr                <= 1'b0;
            comparator_power_on    <= 1'b0;
            reference_input_select <= 1'b0;
            comparator_out_pin     <= 1'b0;
            compare_irq            <= 1'b0;
        end else begin
            csc                    <= next_csc;
            result_prev            <= next_result_prev;
            pready                 <= next_pready;
            prdata                 <= next_prdata;
            pslverr                <= next_pslverr;
            comparator_power_on    <= next_power_on;
            reference_input_select <= next_refsel;
            comparator_out_pin     <= next_pin;
            compare_irq            <= next_irq;
        end
    end
endmodule // acmpc_top

/* File: verif/acmpc_chk.sv */
/*
 port checker for acmpc_top, bound at the foot of this file.
 assumes acmpc_pkg is compiled first and one clock domain.
*/
`timescale 1ns/100ps
module acmpc_chk
    import acmpc_pkg::*;
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0]  pstrb,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire acmpc_pkg::acmpc_pwr_t pwr_state,
    input wire logic        comparator_power_on,
    input wire logic        reference_input_select,
    input wire logic        compare_irq
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic wr_ok;
    logic wr_en;
    logic wr_ref;
    // writes outside run mode, wait included, are left out: the stop forcing wins in stop
    assign wr_ok = psel && penable && pready && pwrite && paddr == ACMPC_CSC_OFFSET
                   && pstrb[0] && pwr_state == ACMPC_PWR_RUN;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            {wr_en, wr_ref} <= 2'h0;
        else if (wr_ok)
            {wr_en, wr_ref} <= pwdata[7:6];
    end
    a_enable_follows: assert property (wr_ok ##1 pwr_state == ACMPC_PWR_RUN
        |=> comparator_power_on == wr_en) else $error("power on differs from enable");
    a_refsel_follows: assert property (wr_ok ##1 pwr_state == ACMPC_PWR_RUN
        |=> reference_input_select == wr_ref) else $error("refsel differs");
    a_stop_powers_off: assert property ((pwr_state inside {ACMPC_PWR_LSTOP,
        ACMPC_PWR_DSTOP})[*2] |-> !comparator_power_on && !compare_irq)
        else $error("active while stopped");
    a_deep_reads_zero: assert property (pready && !pwrite && paddr == ACMPC_CSC_OFFSET
        && pwr_state == ACMPC_PWR_DSTOP && $past(pwr_state, 2) == ACMPC_PWR_DSTOP
        |-> prdata == 32'h0) else $error("deep stop not reset");
    a_light_holds: assert property ((pwr_state == ACMPC_PWR_LSTOP)[*3]
        |-> $stable(reference_input_select)) else $error("light stop changed state");
    a_irq_needs_ie: assert property (compare_irq && $past(compare_irq) && pready
        && !pwrite && paddr == 12'h000 |-> prdata[4]) else $error("irq without enable");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    a_err_with_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    a_result_off_zero: assert property (pready && !pwrite && !pslverr
        && paddr == ACMPC_CSC_OFFSET && !prdata[ACMPC_ENABLE_BIT]
        |-> !prdata[ACMPC_RESULT_BIT]) else $error("result bit set while disabled");
    c_write: cover property (wr_ok);
    c_irq: cover property ($rose(compare_irq));
    c_light: cover property ((pwr_state == ACMPC_PWR_LSTOP)[*3]);
endmodule // acmpc_chk

bind acmpc_top acmpc_chk chk_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pstrb, .prdata, .pready, .pslverr, .pwr_state, .comparator_power_on,
    .reference_input_select, .compare_irq);

/* File: verif/tb_top.sv */
/*
 self-checking bench for acmpc_top over apb.
 assumes the checker file is compiled alongside.
*/
`timescale 1ns/100ps
module tb_top;
    import acmpc_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, debug_halt, comparator_raw;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic [3:0]  pstrb;
    logic        pready, pslverr, comparator_power_on, reference_input_select;
    logic        comparator_out_pin, compare_irq;
    acmpc_pwr_t  pwr_state;
    logic [32:0] expq[$];
    logic [7:0]  cfg;
    int          mismatches, cmp_count, seed;
    acmpc_top dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .pstrb, .prdata, .pready, .pslverr, .pwr_state, .debug_halt, .comparator_raw,
        .comparator_power_on, .reference_input_select, .comparator_out_pin, .compare_irq);
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    task automatic chk(input string nm, input logic [32:0] s, input logic [32:0] e);
        cmp_count++;
        if (s !== e) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic finish_test;
        if (expq.size() != 0) mismatches++;
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic idle(input int k);
        repeat (k) @(posedge pclk);
    endtask
    // upper data bits are random: only bits 7:0 may matter
    task automatic bus(input logic w, input logic [11:0] a, input logic [7:0] d,
                       input logic [32:0] e);
        int k;
        k = 0;
        r = $random(seed);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {r[31:8], d};
        if (!w) expq.push_back(e);
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            k++;
        end while (!pready && k < 20);
        if (!pready) begin
            mismatches++;
            finish_test();
        end
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    always @(posedge pclk) begin
        if (pready && !pwrite)
            chk("read", {pslverr, prdata}, expq.size() ? expq.pop_front() : 33'hX);
    end
    initial begin
        seed = 32'hE1A2;
        {psel, penable, pwrite, debug_halt, comparator_raw, presetn} = 6'h0;
        mismatches = 0;
        cmp_count = 0;
        paddr = 12'h000;
        pwdata = 32'h0;
        pstrb = 4'hF;
        pwr_state = ACMPC_PWR_RUN;
        idle(5);
        presetn <= 1'b1;
        bus(1'b0, 12'h000, 8'h00, 33'h0);
        bus(1'b0, 12'h008, 8'h00, {1'b1, 32'h0});
        for (int m = 0; m < 4; m++) begin
            cfg = 8'hD4 | 8'(m);
            pwr_state <= (m == 2) ? ACMPC_PWR_WAIT : ACMPC_PWR_RUN;
            debug_halt <= m[0];
            bus(1'b1, 12'h000, cfg | 8'h20, 33'h0);
            comparator_raw <= 1'b1;
            idle(12);
            bus(1'b0, 12'h000, 8'h00, {25'h0, cfg | 8'h08 | (m[0] ? 8'h20 : 8'h00)});
            chk("irq", 33'(compare_irq), 33'(m[0]));
            chk("pin", 33'(comparator_out_pin), 33'h1);
            chk("refsel", 33'(reference_input_select), 33'h1);
            bus(1'b1, 12'h000, cfg | 8'h20, 33'h0);
            comparator_raw <= 1'b0;
            idle(12);
            bus(1'b0, 12'h000, 8'h00, {25'h0, cfg | (m == 1 ? 8'h00 : 8'h20)});
            chk("irq", 33'(compare_irq), 33'(m != 1));
        end
        pwr_state <= ACMPC_PWR_RUN;
        bus(1'b1, 12'h000, 8'h20, 33'h0);
        comparator_raw <= 1'b1;
        idle(12);
        bus(1'b0, 12'h000, 8'h00, 33'h0);
        chk("pin", 33'(comparator_out_pin), 33'h0);
        // enabling in rise mode while the result is already high: no event
        bus(1'b1, 12'h000, 8'hD5, 33'h0);
        idle(12);
        bus(1'b0, 12'h000, 8'h00, {25'h0, 8'hDD});
        comparator_raw <= 1'b0;
        idle(12);
        bus(1'b1, 12'h000, 8'hD7, 33'h0);
        idle(12);
        pwr_state <= ACMPC_PWR_LSTOP;
        idle(3);
        chk("power", 33'(comparator_power_on), 33'h0);
        comparator_raw <= 1'b1;
        idle(12);
        comparator_raw <= 1'b0;
        idle(12);
        pwr_state <= ACMPC_PWR_RUN;
        idle(12);
        bus(1'b0, 12'h000, 8'h00, {25'h0, 8'hD7});
        pwr_state <= ACMPC_PWR_DSTOP;
        idle(3);
        bus(1'b0, 12'h000, 8'h00, 33'h0);
        pwr_state <= ACMPC_PWR_RUN;
        idle(2);
        bus(1'b0, 12'h000, 8'h00, 33'h0);
        idle(3);
        finish_test();
    end
endmodule // tb_top
